// *** core/tmon_pkg.sv ***
// Purpose: shared constants of the temperature monitor register bank
// Assumes: 20 MHz mclk
// Notes:   offsets are 8-bit pointer values
package tmon_pkg;
   localparam logic [7:0] A_LOCAL     = 8'h00;
   localparam logic [7:0] A_REM_HI    = 8'h01;
   localparam logic [7:0] A_CFG_RD    = 8'h03;
   localparam logic [7:0] A_RATE_RD   = 8'h04;
   localparam logic [7:0] A_CFG_WR    = 8'h09;
   localparam logic [7:0] A_RATE_WR   = 8'h0A;
   localparam logic [7:0] A_REM_LO    = 8'h10;
   localparam logic [7:0] PTR_RST     = 8'h00;
   localparam logic [7:0] RES_RST     = 8'h00;
   localparam logic [7:0] CFG_RST     = 8'h00;
   localparam logic [7:0] CFG_USED    = 8'hE4;
   localparam logic [3:0] RATE_RST    = 4'h8;
   localparam logic [3:0] RATE_MAX    = 4'hA;
   localparam int         RATE_W      = 4;
   localparam int         CFG_MASK_B  = 7;
   localparam int         CFG_STBY_B  = 6;
   localparam int         CFG_PFS_B   = 5;
   localparam int         CFG_RANGE_B = 2;
   localparam int         FRAC_W      = 2;
   localparam int         EXT_OFFSET  = 64;
   localparam int         BIN_MAX     = 127;
   localparam int         EXT_MAX     = 255;
   localparam int         DIV_W       = 11;
   localparam int         CONV_FAST_US = 15500;
   localparam int         CLK_MHZ     = 20;
   localparam int         CONV_FAST_CYC = CONV_FAST_US * CLK_MHZ;
   localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A; // arbitrary value
endpackage

// *** core/smbus_byte_slave.sv ***
// Purpose: two-wire serial slave, byte level, open-drain data pin
// Assumes: scl and sda arrive from pins; host clock far below mclk
// Notes:   reads take rd_data on the scl fall ending the acknowledge bit, at least one scl high phase after rd_req
`timescale 1ns/1ps
`default_nettype none
module smbus_byte_slave
   import tmon_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            wr_valid,
   output logic            wr_first,
   output logic [7:0]      wr_data,
   output logic            rd_req,
   output logic            rd_take,
   input  wire logic [7:0] rd_data
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WR, S_RD, S_RD_ACK, S_RD_LOAD} st_t;
   st_t        st_q;
   logic [2:0] scl_q, sda_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic       rw_q, first_q, ackd_q;
   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   wire stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   wire [7:0] sh_in = {sh_q[6:0], sda_q[1]};
   assign sda_out = 1'b0;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
         st_q <= S_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         ackd_q <= 1'b0;
         sda_oe <= 1'b0;
         wr_valid <= 1'b0;
         wr_first <= 1'b0;
         wr_data <= 8'h00;
         rd_req <= 1'b0;
         rd_take <= 1'b0;
      end else if (clk_en) begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
         wr_valid <= 1'b0;
         rd_req <= 1'b0;
         rd_take <= 1'b0;
         if (start_c) begin
            st_q <= S_ADDR;
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st_q <= S_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st_q)
               S_ADDR: if (scl_rise) begin
                  sh_q <= sh_in;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     rw_q <= sda_q[1];
                     ackd_q <= 1'b0;
                     st_q <= (sh_q[6:0] == SLAVE_ADDR) ? S_ACK : S_IDLE;
                     rd_req <= (sh_q[6:0] == SLAVE_ADDR) & sda_q[1];
                  end
               end
               S_ACK: if (scl_fall) begin
                  if (!ackd_q) begin
                     ackd_q <= 1'b1;
                     sda_oe <= 1'b1;
                  end else if (rw_q) begin
                     sh_q <= rd_data;
                     sda_oe <= ~rd_data[7];
                     cnt_q <= 4'h1;
                     rd_take <= 1'b1;
                     st_q <= S_RD;
                  end else begin
                     sda_oe <= 1'b0;
                     cnt_q <= 4'h0;
                     st_q <= S_WR;
                  end
               end
               S_WR: if (scl_rise) begin
                  sh_q <= sh_in;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     wr_valid <= 1'b1;
                     wr_first <= first_q;
                     wr_data <= sh_in;
                     first_q <= 1'b0;
                     ackd_q <= 1'b0;
                     st_q <= S_ACK;
                  end
               end
               S_RD: if (scl_fall) begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  cnt_q <= cnt_q + 4'h1;
                  sda_oe <= (cnt_q == 4'h8) ? 1'b0 : ~sh_q[6];
                  if (cnt_q == 4'h8) st_q <= S_RD_ACK;
               end
               S_RD_ACK: if (scl_rise) begin
                  st_q <= sda_q[1] ? S_IDLE : S_RD_LOAD;
                  rd_req <= ~sda_q[1];
               end
               S_RD_LOAD: if (scl_fall) begin
                  sh_q <= rd_data;
                  sda_oe <= ~rd_data[7];
                  cnt_q <= 4'h1;
                  rd_take <= 1'b1;
                  st_q <= S_RD;
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** core/temp_monitor_register_bank.sv ***
// Purpose: register bank of a two-channel temperature monitor
// Assumes: converter on mclk gives signed quarter-degree results with conv_done
// Notes:   registers reached only through the two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_register_bank
   import tmon_pkg::*;
#(
   parameter int         TEMP_W      = 12,
   parameter int         BASE_CYCLES = CONV_FAST_CYC,
   parameter logic [6:0] SLAVE_ADDR  = SLAVE_ADDR_DEF
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   input  wire logic              conv_done,
   input  wire logic [TEMP_W-1:0] local_temp_in,
   input  wire logic [TEMP_W-1:0] remote_temp_in,
   output logic                   conv_start,
   output logic                   standby,
   output logic                   extended_range,
   output logic                   pin_function_select,
   output logic                   alert_enable
);
   logic [7:0]       pointer_q, config_q, local_q, rhi_q, rlo_q, rd_data_q;
   logic [RATE_W-1:0] rate_q;
   logic             freeze_q;
   logic [31:0]      base_cnt_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic             wr_valid, wr_first, rd_req, rd_take;
   logic [7:0]       wr_data;

   smbus_byte_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_port (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe   (sda_oe),
      .wr_valid (wr_valid),
      .wr_first (wr_first),
      .wr_data  (wr_data),
      .rd_req   (rd_req),
      .rd_take  (rd_take),
      .rd_data  (rd_data_q)
   );

   // temperature to register code: {high byte, two fraction bits}
   function automatic logic [9:0] encode(input logic [TEMP_W-1:0] t, input logic ext);
      int deg;
      int v;
      logic [9:0] r;
      deg = int'($signed(t)) >>> FRAC_W;
      v = ext ? deg + EXT_OFFSET : deg;
      if (v < 0)
         r = 10'h000;
      else if (v > (ext ? EXT_MAX : BIN_MAX))
         r = {8'(ext ? EXT_MAX : BIN_MAX), 2'b00};
      else
         r = {8'(v), t[FRAC_W-1:0]};
      return r;
   endfunction

   wire ext_w       = config_q[CFG_RANGE_B];
   wire [9:0] loc_e = encode(local_temp_in, ext_w);
   wire [9:0] rem_e = encode(remote_temp_in, ext_w);
   wire data_wr     = wr_valid & ~wr_first;
   wire cfg_wr      = data_wr & (pointer_q == A_CFG_WR);
   wire rate_wr     = data_wr & (pointer_q == A_RATE_WR);
   wire hi_take     = rd_take & (pointer_q == A_REM_HI);
   wire lo_take     = rd_take & (pointer_q == A_REM_LO);
   wire [3:0] rate_eff = (rate_q > RATE_MAX) ? RATE_MAX : rate_q;
   wire [DIV_W-1:0] div_top = DIV_W'((1 << (RATE_MAX - rate_eff)) - 1);
   wire base_tick   = (base_cnt_q == 32'(BASE_CYCLES - 1));
   wire interval_end = base_tick & (div_cnt_q == div_top);
   wire running     = ~config_q[CFG_STBY_B];

   logic [7:0] rd_mux;
   always_comb begin
      case (pointer_q)
         A_LOCAL:   rd_mux = local_q;
         A_REM_HI:  rd_mux = rhi_q;
         A_REM_LO:  rd_mux = rlo_q;
         A_CFG_RD:  rd_mux = config_q;
         A_RATE_RD: rd_mux = {{(8-RATE_W){1'b0}}, rate_q};
         default:   rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         pointer_q <= PTR_RST;
      else if (clk_en && wr_valid && wr_first)
         pointer_q <= wr_data;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         rd_data_q <= 8'h00;
      else if (clk_en && rd_req)
         rd_data_q <= rd_mux;
   end

   // only the two writable views exist; every other address drops the byte
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         config_q <= CFG_RST;
         rate_q <= RATE_RST;
      end else if (clk_en) begin
         if (cfg_wr)
            config_q <= wr_data & CFG_USED;
         if (rate_wr)
            rate_q <= wr_data[RATE_W-1:0];
      end
   end

   // results written by the converter alone; limits live elsewhere
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         local_q <= RES_RST;
         rhi_q <= RES_RST;
         rlo_q <= RES_RST;
         freeze_q <= 1'b0;
      end else if (clk_en) begin
         if (conv_done) begin
            local_q <= loc_e[9:2];
            rlo_q <= {rem_e[1:0], 6'h00};
            if (!freeze_q || hi_take)
               rhi_q <= rem_e[9:2];
         end
         if (lo_take)
            freeze_q <= 1'b1;
         else if (hi_take)
            freeze_q <= 1'b0;
      end
   end

   // interval timer: fast base period times 2^(10-code), codes above 10 taken as 10
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         base_cnt_q <= 32'h0;
         div_cnt_q <= '0;
         conv_start <= 1'b0;
      end else if (clk_en) begin
         conv_start <= running & interval_end;
         if (!running || rate_wr) begin
            base_cnt_q <= 32'h0;
            div_cnt_q <= '0;
         end else if (base_tick) begin
            base_cnt_q <= 32'h0;
            div_cnt_q <= interval_end ? '0 : div_cnt_q + 1'b1;
         end else
            base_cnt_q <= base_cnt_q + 32'h1;
      end
   end

   // comparators sit outside; these levels ignore standby
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         standby <= 1'b0;
         extended_range <= 1'b0;
         pin_function_select <= 1'b0;
         alert_enable <= 1'b0;
      end else if (clk_en) begin
         standby <= config_q[CFG_STBY_B];
         extended_range <= ext_w;
         pin_function_select <= config_q[CFG_PFS_B];
         alert_enable <= ~config_q[CFG_MASK_B] & ~config_q[CFG_PFS_B];
      end
   end

   sequence s_ptr_write;
      clk_en && wr_valid && wr_first;
   endsequence

   property p_ptr_load;
      @(posedge mclk) disable iff (!reset_n)
      s_ptr_write |=> pointer_q == $past(wr_data);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

   property p_ptr_hold;
      @(posedge mclk) disable iff (!reset_n)
      !(wr_valid && wr_first) |=> $stable(pointer_q);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

   property p_cfg_write;
      @(posedge mclk) disable iff (!reset_n)
      clk_en && data_wr && pointer_q == A_CFG_WR |=> config_q == ($past(wr_data) & CFG_USED);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_result_ro;
      @(posedge mclk) disable iff (!reset_n)
      !conv_done |=> $stable(local_q) && $stable(rlo_q);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result changed by bus");

   property p_binary_clamp;
      @(posedge mclk) disable iff (!reset_n)
      clk_en && conv_done && !ext_w |=> local_q <= 8'h7F;
   endproperty
   a_binary_clamp: assert property (p_binary_clamp) else $error("binary result over 127");

   property p_ext_zero;
      @(posedge mclk) disable iff (!reset_n)
      clk_en && conv_done && ext_w && local_temp_in == '0 |=> local_q == 8'h40;
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("offset binary zero wrong");

   property p_freeze;
      @(posedge mclk) disable iff (!reset_n)
      freeze_q && !hi_take |=> $stable(rhi_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("high byte moved while frozen");

   property p_low_bits;
      @(posedge mclk) disable iff (!reset_n)
      rlo_q[5:0] == 6'h00;
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("low byte spare bits set");

   property p_standby;
      @(posedge mclk) disable iff (!reset_n)
      config_q[CFG_STBY_B] ##1 config_q[CFG_STBY_B] |-> !conv_start;
   endproperty
   a_standby: assert property (p_standby) else $error("conversion in standby");

   property p_alert;
      @(posedge mclk) disable iff (!reset_n)
      clk_en && config_q[CFG_PFS_B] |=> !alert_enable;
   endproperty
   a_alert: assert property (p_alert) else $error("mask not ignored");
endmodule
`default_nettype wire

// *** test/smbus_host_model.sv ***
// Purpose: host controller on the two-wire serial port, bit-banged on mclk
// Assumes: open-drain lines with pull-ups; one target at ADDR
// Notes:   scl period 18 mclk; a released line reads high
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
   import tmon_pkg::*;
#(
   parameter logic [6:0] ADDR = SLAVE_ADDR_DEF
) (
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // data changes only while scl is low, sampled late in the high phase
   task automatic xfer(input logic b, output logic r);
      sda_low <= ~b;
      tick(6);
      scl <= 1'b1;
      tick(6);
      r = sda_line;
      scl <= 1'b0;
      tick(6);
   endtask
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask
   // start: sda falls while scl is high; stop: sda rises while scl is high
   task automatic cond(input logic stop);
      sda_low <= stop;
      tick(6);
      scl <= 1'b1;
      tick(6);
      sda_low <= ~stop;
      tick(6);
      if (!stop) scl <= 1'b0;
      tick(6);
   endtask
   // pointer byte always goes first in a write
   task automatic wr(input logic [7:0] ptr, input logic with_data, input logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      a2 = 1'b1;
      cond(1'b0);
      byte_out({ADDR, 1'b0}, a0);
      byte_out(ptr, a1);
      if (with_data) byte_out(d, a2);
      cond(1'b1);
      ok = a0 & a1 & a2;
   endtask
   // single-byte read ended by a not-acknowledge
   task automatic rd(output logic [7:0] d, output logic ok);
      logic r;
      cond(1'b0);
      byte_out({ADDR, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(1'b1, r);
      cond(1'b1);
   endtask
endmodule
`default_nettype wire

// *** test/temp_monitor_register_bank_tb.sv ***
// Purpose: self-checking bench of the temperature monitor register bank
// Assumes: converter modelled here; conv_done one cycle after conv_start
// Notes:   BASE_CYCLES shortened to 8, so code 0x08 gives 32 cycles
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_register_bank_tb
   import tmon_pkg::*;
;
   localparam int BASE = 8;
   // temperature, range bit, expected high byte, expected low byte
   localparam logic [31:0] ENC [7] = '{32'h067019C0, 32'hF2400000, 32'h25807F00, 32'hF2410900,
                                       32'h00014000, 32'h2591D640, 32'hEFC10000};
   // config value, then standby, extended_range, pin_function_select, alert_enable
   localparam logic [11:0] CFG [6] = '{12'h800, 12'h001, 12'hA02, 12'h202, 12'h045, 12'h409};
   logic        mclk;
   logic        reset_n;
   logic        clk_en;
   logic        conv_done;
   logic [11:0] local_t;
   logic [11:0] remote_t;
   logic        scl;
   logic        sda_low;
   logic        sda_out;
   logic        sda_oe;
   logic        conv_start;
   logic        standby;
   logic        extended_range;
   logic        pin_function_select;
   logic        alert_enable;
   wire logic   sda_line = ~(sda_low | (sda_oe & ~sda_out));
   int          n_errors;
   int          checks;
   int          n_starts;
   temp_monitor_register_bank #(.BASE_CYCLES(BASE)) u_dut (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done), .local_temp_in(local_t),
      .remote_temp_in(remote_t), .conv_start(conv_start), .standby(standby),
      .extended_range(extended_range), .pin_function_select(pin_function_select),
      .alert_enable(alert_enable));
   smbus_host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   always #25 mclk = ~mclk;
   always @(posedge mclk) conv_done <= conv_start;
   always @(negedge mclk) if (conv_start === 1'b1) n_starts++;
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      u_host.wr(a, 1'b1, d, ok);
      chk({15'h0, ok}, 16'h0001);
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      logic       ok;
      logic [7:0] v;
      u_host.wr(a, 1'b0, 8'h00, ok);
      u_host.rd(v, ok);
      chk({8'h00, v}, {8'h00, e});
   endtask
   task automatic expect_rd(input logic [7:0] e);
      logic       ok;
      logic [7:0] v;
      u_host.rd(v, ok);
      chk({8'h00, v}, {8'h00, e});
   endtask
   // returns the cycles up to the next conversion start
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (conv_start !== 1'b1 && n < 20000);
      if (conv_start !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t no conversion start", $time);
         give_verdict();
      end
   endtask
   initial begin
      int          n;
      int          s;
      logic        ok;
      logic [31:0] e;
      mclk     = 1'b0;
      reset_n  = 1'b0;
      clk_en   = 1'b1;
      conv_done = 1'b0;
      local_t  = 12'h064;
      remote_t = 12'h067;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      expect_rd(8'h19);
      expect_reg(A_REM_LO, 8'hC0);
      expect_reg(A_REM_HI, 8'h19);
      expect_reg(A_CFG_RD, CFG_RST);
      expect_reg(A_RATE_RD, {4'h0, RATE_RST});
      wait_pulse(n);
      wait_pulse(n);
      chk(16'(n), 16'(BASE << 2));
      for (int i = 0; i < 6; i++) begin
         wreg(A_CFG_WR, CFG[i][11:4]);
         chk({12'h000, standby, extended_range, pin_function_select, alert_enable}, {12'h000, CFG[i][3:0]});
         expect_reg(A_CFG_RD, CFG[i][11:4]);
      end
      s = n_starts;
      expect_reg(A_CFG_RD, 8'h40);
      chk(16'(n_starts - s), 16'h0000);
      for (int i = 0; i < 7; i++) begin
         e = ENC[i];
         local_t  <= e[31:20];
         remote_t <= e[31:20];
         wreg(A_CFG_WR, {5'h00, e[16], 2'h0});
         wait_pulse(n);
         wait_pulse(n);
         expect_reg(A_LOCAL, e[15:8]);
         expect_reg(A_REM_LO, e[7:0]);
         expect_reg(A_REM_HI, e[15:8]);
      end
      local_t  <= 12'h067;
      remote_t <= 12'h067;
      wreg(A_CFG_WR, 8'h00);
      foreach (CFG[i]) wreg(i == 5 ? 8'h05 : 8'(i), 8'h04);
      expect_reg(A_LOCAL, 8'h19);
      expect_reg(A_CFG_RD, 8'h00);
      expect_reg(A_RATE_RD, 8'h08);
      expect_reg(8'h05, 8'h00);
      expect_rd(8'h00);
      for (int c = 11; c >= 0; c--) begin
         wreg(A_RATE_WR, 8'(c));
         expect_reg(A_RATE_RD, 8'(c));
         wait_pulse(n);
         wait_pulse(n);
         chk(16'(n), 16'(BASE << (10 - ((c > 10) ? 10 : c))));
      end
      wreg(A_RATE_WR, 8'h04);
      expect_reg(A_REM_LO, 8'hC0);
      u_host.wr(A_REM_HI, 1'b0, 8'h00, ok);
      remote_t <= 12'h190;
      wait_pulse(n);
      expect_rd(8'h19);
      wait_pulse(n);
      wait_pulse(n);
      expect_rd(8'h64);
      give_verdict();
   end
endmodule
`default_nettype wire
